// [hdl/ocp_compare.sv]
// Output compare and simple PWM channels with two shared timebases
//
// How it works
// - Each channel picks timebase a or b by control bit 3; a is default.
// - Modes 001, 010, 011 drive pin low, high, or toggle on a main match.
// - Single compare matches the main value; a wrap before it leaves the pin.
// - Mode 100 gives one pulse, mode 101 a continuous pulse train.
// - Main match starts the dual compare pulse, secondary match ends it.
// - Rewriting mode 100 arms a fresh single pulse.
// - Modes 110 and 111 are PWM; 111 adds fault protection.
// - In PWM the main register is the read-only duty latch, secondary buffers.
// - A low fault input in mode 111 floats the pin at once.
// - Control bit 4 reads back the fault state.
// - Fault clears only with fault input high and a rewrite of PWM mode.
// - PWM period is period value plus one times prescale instruction cycles.
// - After period match the next increment clears the timer and sets its flag together.
// - Each rollover sets the pin high unless duty is zero.
// - Each rollover copies the buffered duty into the duty latch.
// - Up to eight channels, each with own control, main, secondary values.
// - Single compare matches and dual compare pulse ends set the channel flag; PWM never does.
// - In idle the channel runs only with its idle-stop bit 13 clear.
// - In sleep the pin holds its level and operation resumes on wake.
`timescale 1ns/1ps
`include "ocp_cfg.svh"

module ocp_compare
  import ocp_pkg::*;
#(
  parameter int NUM_CH = 8
)
(
  input wire logic mclk,
  input wire logic rst,
  input ocp_wr_t ch_wr,
  input ocp_tbwr_t tb_wr,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic fault_input_a_n,
  input wire logic fault_input_b_n,
  input wire logic [NUM_CH-1:0] compare_irq_clr,
  input wire logic timebase_a_irq_clr,
  input wire logic timebase_b_irq_clr,
  output logic [NUM_CH-1:0] compare_output_pin,
  output logic [NUM_CH-1:0] compare_output_pin_oe,
  output logic [NUM_CH-1:0] compare_irq_flag,
  output logic [NUM_CH-1:0] fault_flag,
  output logic [NUM_CH-1:0][15:0] compare_control_rd,
  output logic [NUM_CH-1:0][15:0] compare_main_rd,
  output logic [NUM_CH-1:0][15:0] compare_secondary_rd,
  output logic [15:0] timer_count_a,
  output logic [15:0] timer_count_b,
  output logic timebase_a_irq_flag,
  output logic timebase_b_irq_flag
);

  // ****************************************
  // Fault input synchronisers
  // ****************************************

  logic flt_a_meta_reg;
  logic flt_a_reg;
  logic flt_b_meta_reg;
  logic flt_b_reg;

  // Two flops per fault pin, idle level high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flt_a_meta_reg <= 1'b1;
      flt_a_reg <= 1'b1;
      flt_b_meta_reg <= 1'b1;
      flt_b_reg <= 1'b1;
    end else begin
      flt_a_meta_reg <= fault_input_a_n;
      flt_a_reg <= flt_a_meta_reg;
      flt_b_meta_reg <= fault_input_b_n;
      flt_b_reg <= flt_b_meta_reg;
    end
  end

  // ****************************************
  // Timebases
  // ****************************************

  ocp_tb_t tb_a;
  ocp_tb_t tb_b;
  logic tb_run;

  // Timers use the instruction clock, so they stop in sleep
  assign tb_run = !cpu_sleep;

  // Timebase a, the default selection
  ocp_timebase u_tb_a (
    .mclk(mclk),
    .rst(rst),
    .period_we(tb_wr.period_we && !tb_wr.tsel),
    .control_we(tb_wr.control_we && !tb_wr.tsel),
    .wdata(tb_wr.data),
    .run(tb_run),
    .irq_clr(timebase_a_irq_clr),
    .status(tb_a),
    .irq_flag(timebase_a_irq_flag)
  );

  // Timebase b
  ocp_timebase u_tb_b (
    .mclk(mclk),
    .rst(rst),
    .period_we(tb_wr.period_we && tb_wr.tsel),
    .control_we(tb_wr.control_we && tb_wr.tsel),
    .wdata(tb_wr.data),
    .run(tb_run),
    .irq_clr(timebase_b_irq_clr),
    .status(tb_b),
    .irq_flag(timebase_b_irq_flag)
  );

  assign timer_count_a = tb_a.count;
  assign timer_count_b = tb_b.count;

  // ****************************************
  // Compare channels
  // ****************************************

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [2:0] IDX = 3'(i);

    ocp_mode_t mode_reg;
    logic tsel_reg;
    logic sidl_reg;
    logic [15:0] compare_main_reg;
    logic [15:0] compare_secondary_reg;
    logic pin_reg;
    logic fault_reg;
    logic irq_reg;
    ocp_dual_t dual_reg;

    logic pin_next;
    ocp_dual_t dual_next;
    logic [15:0] main_next;
    logic event_hit;

    // Write decode for this channel
    wire sel = (ch_wr.ch == IDX);
    wire ctrl_we = ch_wr.ctrl_we && sel;
    wire main_we = ch_wr.main_we && sel;
    wire sec_we = ch_wr.sec_we && sel;
    wire [2:0] new_mode = ch_wr.data[`OCP_MODE_MSB:`OCP_MODE_LSB];

    // Mode decode
    wire pwm_m = (mode_reg == OCP_PWM) || (mode_reg == OCP_PWMF);
    wire new_pwm = (new_mode == OCP_PWM) || (new_mode == OCP_PWMF);
    wire new_dual = (new_mode == OCP_ONE) || (new_mode == OCP_TRAIN);

    // Timebase selection
    ocp_tb_t tb;
    assign tb = tsel_reg ? tb_b : tb_a;

    // Halt in sleep, and in idle when asked to stop there
    wire run = !cpu_sleep && !(cpu_idle && sidl_reg);

    // Match strobes on each new count value
    wire hit_m = run && tb.upd && (tb.count == compare_main_reg);
    wire hit_s = run && tb.upd && (tb.count == compare_secondary_reg);
    wire wrap = run && tb.wrap;

    // Fault pin group and fault state
    wire flt_low = (i < `OCP_FAULT_A_CHANNELS) ? !flt_a_reg : !flt_b_reg;
    wire flt_set = (mode_reg == OCP_PWMF) && flt_low;
    wire flt_clr = ctrl_we && new_pwm && !flt_low;

    // Pin, pulse sequence and duty latch next values
    always_comb begin
      pin_next = pin_reg;
      dual_next = dual_reg;
      main_next = compare_main_reg;
      event_hit = 1'b0;
      case (mode_reg)
        OCP_OFF: begin
          pin_next = 1'b0;
        end
        OCP_LOW: begin
          if (hit_m) begin
            pin_next = 1'b0;
            event_hit = 1'b1;
          end
        end
        OCP_HIGH: begin
          if (hit_m) begin
            pin_next = 1'b1;
            event_hit = 1'b1;
          end
        end
        OCP_TOG: begin
          if (hit_m) begin
            pin_next = !pin_reg;
            event_hit = 1'b1;
          end
        end
        OCP_ONE, OCP_TRAIN: begin
          case (dual_reg)
            OCP_ST_ARM: begin
              if (hit_m) begin
                pin_next = 1'b1;
                dual_next = OCP_ST_HIGH;
              end
            end
            OCP_ST_HIGH: begin
              if (hit_s) begin
                pin_next = 1'b0;
                event_hit = 1'b1;
                dual_next = (mode_reg == OCP_TRAIN) ? OCP_ST_ARM : OCP_ST_DONE;
              end
            end
            OCP_ST_DONE: begin
              pin_next = 1'b0;
            end
            default: begin
              dual_next = OCP_ST_DONE;
            end
          endcase
        end
        OCP_PWM, OCP_PWMF: begin
          if (wrap) begin
            main_next = compare_secondary_reg;
            pin_next = (compare_secondary_reg != `OCP_RST16);
          end else if (hit_m) begin
            pin_next = 1'b0;
          end
        end
        default: begin
          pin_next = pin_reg;
        end
      endcase
    end

    // Control, compare values and pin state
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        mode_reg <= OCP_OFF;
        tsel_reg <= 1'b0;
        sidl_reg <= 1'b0;
        compare_main_reg <= `OCP_RST16;
        compare_secondary_reg <= `OCP_RST16;
        pin_reg <= 1'b0;
        dual_reg <= OCP_ST_DONE;
      end else begin
        pin_reg <= pin_next;
        compare_main_reg <= main_next;
        dual_reg <= dual_next;
        if (ctrl_we) begin
          mode_reg <= ocp_mode_t'(new_mode);
          tsel_reg <= ch_wr.data[`OCP_TSEL_BIT];
          sidl_reg <= ch_wr.data[`OCP_SIDL_BIT];
          if (new_dual) dual_reg <= OCP_ST_ARM;
        end
        if (main_we && !pwm_m) compare_main_reg <= ch_wr.data;
        if (sec_we) compare_secondary_reg <= ch_wr.data;
      end
    end

    // Sticky fault and compare flags, set wins over clear
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        fault_reg <= 1'b0;
        irq_reg <= 1'b0;
      end else begin
        fault_reg <= flt_set || (fault_reg && !flt_clr);
        irq_reg <= (event_hit && !pwm_m) || (irq_reg && !compare_irq_clr[i]);
      end
    end

    // Pin floats at once on a fault, and while the channel is off
    assign compare_output_pin[i] = pin_reg;
    assign compare_output_pin_oe[i] = (mode_reg != OCP_OFF) && !fault_reg && !flt_set;
    assign compare_irq_flag[i] = irq_reg;
    assign fault_flag[i] = fault_reg;

    // Readback words
    always_comb begin
      compare_control_rd[i] = `OCP_RST16;
      compare_control_rd[i][`OCP_MODE_MSB:`OCP_MODE_LSB] = mode_reg;
      compare_control_rd[i][`OCP_TSEL_BIT] = tsel_reg;
      compare_control_rd[i][`OCP_FLT_BIT] = fault_reg;
      compare_control_rd[i][`OCP_SIDL_BIT] = sidl_reg;
    end
    assign compare_main_rd[i] = compare_main_reg;
    assign compare_secondary_rd[i] = compare_secondary_reg;
  end

endmodule : ocp_compare

// [hdl/ocp_timebase.sv]
// One 16-bit timebase with prescaler, period register and interrupt flag
`timescale 1ns/1ps
`include "ocp_cfg.svh"

module ocp_timebase
  import ocp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic period_we,
  input wire logic control_we,
  input wire logic [15:0] wdata,
  input wire logic run,
  input wire logic irq_clr,
  output ocp_tb_t status,
  output logic irq_flag
);

  logic [15:0] count_reg;
  logic [15:0] period_reg;
  logic on_reg;
  logic [1:0] ps_sel_reg;
  logic [7:0] ps_cnt_reg;
  logic upd_reg;
  logic wrap_reg;
  logic irq_reg;
  logic [7:0] ps_lim;
  logic step;
  logic at_end;

  // Prescale terminal count
  assign ps_lim = (ps_sel_reg == 2'h0) ? `OCP_PS_LIM1 :
                  (ps_sel_reg == 2'h1) ? `OCP_PS_LIM8 :
                  (ps_sel_reg == 2'h2) ? `OCP_PS_LIM64 : `OCP_PS_LIM256;
  assign step = on_reg && run && (ps_cnt_reg == ps_lim);
  assign at_end = (count_reg == period_reg);

  // Count, clear at period, flag the rollover
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg <= `OCP_RST16;
      period_reg <= `OCP_RST16;
      on_reg <= 1'b0;
      ps_sel_reg <= 2'h0;
      ps_cnt_reg <= 8'h00;
      upd_reg <= 1'b0;
      wrap_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      if (period_we) period_reg <= wdata;
      if (control_we) begin
        on_reg <= wdata[`OCP_TON_BIT];
        ps_sel_reg <= wdata[`OCP_PS_MSB:`OCP_PS_LSB];
      end
      if (!on_reg || step) ps_cnt_reg <= 8'h00;
      else if (run) ps_cnt_reg <= ps_cnt_reg + 8'h01;
      if (step) count_reg <= at_end ? `OCP_RST16 : count_reg + 16'h0001;
      upd_reg <= step;
      wrap_reg <= step && at_end;
      irq_reg <= (step && at_end) || (irq_reg && !irq_clr); // Set wins
    end
  end

  assign status = '{on: on_reg, upd: upd_reg, wrap: wrap_reg, count: count_reg};
  assign irq_flag = irq_reg;

endmodule : ocp_timebase

// [inc/ocp_cfg.svh]
// Bit positions, reset values and prescale counts of the output compare block
`ifndef OCP_CFG_SVH
`define OCP_CFG_SVH

// ****************************************
// Channel control word layout
// ****************************************
`define OCP_MODE_LSB 0
`define OCP_MODE_MSB 2
`define OCP_TSEL_BIT 3
`define OCP_FLT_BIT 4
`define OCP_SIDL_BIT 13

// ****************************************
// Timer control word layout
// ****************************************
`define OCP_TON_BIT 15
`define OCP_PS_LSB 4
`define OCP_PS_MSB 5

// ****************************************
// Reset values and counts
// ****************************************
`define OCP_RST16 16'h0000
`define OCP_PS_LIM1 8'h00
`define OCP_PS_LIM8 8'h07
`define OCP_PS_LIM64 8'h3f
`define OCP_PS_LIM256 8'hff
`define OCP_FAULT_A_CHANNELS 4

`endif

// [inc/ocp_pkg.sv]
// Types shared by the output compare block and its timebases
package ocp_pkg;

  // Channel mode field codes
  typedef enum logic [2:0] {
    OCP_OFF = 3'h0,
    OCP_LOW = 3'h1,
    OCP_HIGH = 3'h2,
    OCP_TOG = 3'h3,
    OCP_ONE = 3'h4,
    OCP_TRAIN = 3'h5,
    OCP_PWM = 3'h6,
    OCP_PWMF = 3'h7
  } ocp_mode_t;

  // Dual compare pulse sequence, one-hot
  typedef enum logic [2:0] {
    OCP_ST_DONE = 3'b001,
    OCP_ST_ARM = 3'b010,
    OCP_ST_HIGH = 3'b100
  } ocp_dual_t;

  // Software write to one channel
  typedef struct packed {
    logic [2:0] ch;
    logic ctrl_we;
    logic main_we;
    logic sec_we;
    logic [15:0] data;
  } ocp_wr_t;

  // Software write to one timebase
  typedef struct packed {
    logic tsel;
    logic period_we;
    logic control_we;
    logic [15:0] data;
  } ocp_tbwr_t;

  // Timebase state seen by the channels
  typedef struct packed {
    logic on;
    logic upd;
    logic wrap;
    logic [15:0] count;
  } ocp_tb_t;

endpackage : ocp_pkg

// [verif/ocp_compare_props.sv]
// Port checker for the output compare block, channel 0 on timebase a
`timescale 1ns/1ps
module ocp_compare_props
  import ocp_pkg::*;
#(
  parameter int NUM_CH = 8
)
(
  input wire logic mclk,
  input wire logic rst,
  input ocp_tbwr_t tb_wr,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic fault_input_a_n,
  input wire logic [NUM_CH-1:0] compare_output_pin,
  input wire logic [NUM_CH-1:0] compare_output_pin_oe,
  input wire logic [NUM_CH-1:0] compare_irq_flag,
  input wire logic [NUM_CH-1:0] fault_flag,
  input wire logic [NUM_CH-1:0][15:0] compare_control_rd,
  input wire logic [NUM_CH-1:0][15:0] compare_main_rd,
  input wire logic [NUM_CH-1:0][15:0] compare_secondary_rd,
  input wire logic [15:0] timer_count_a,
  input wire logic timebase_a_irq_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Channel 0 mode and run conditions
  wire logic [2:0] mode0 = compare_control_rd[0][2:0];
  wire logic pwm0 = mode0[2] & mode0[1];
  wire logic run0 = !cpu_sleep && !cpu_idle && !compare_control_rd[0][3];
  wire logic [15:0] duty0 = compare_main_rd[0];
  // Period rollover and compare hit steps
  sequence s_wrap;
    run0 && pwm0 && $past(pwm0) && $past(timer_count_a) != 16'h0000 && timer_count_a == 16'h0000;
  endsequence
  sequence s_hit;
    run0 && $changed(timer_count_a) && timer_count_a == duty0 && duty0 != 16'h0000;
  endsequence
  a_flag_readback: assert property (compare_control_rd[0][4] == fault_flag[0])
    else $error("fault bit differs from fault flag");
  a_fault_float: assert property (fault_flag[0] |-> !compare_output_pin_oe[0])
    else $error("pin driven while faulted");
  a_fault_catch: assert property ((mode0 == 3'h7 && !fault_input_a_n) [*5] |-> fault_flag[0])
    else $error("fault not caught");
  a_pwm_quiet: assert property (pwm0 && $past(pwm0) |-> !$rose(compare_irq_flag[0]))
    else $error("channel flag set in pwm");
  a_duty_copy: assert property (s_wrap |=> duty0 == $past(compare_secondary_rd[0]))
    else $error("duty not latched at rollover");
  a_period_set: assert property (!fault_flag[0] ##0 s_wrap |=>
    compare_output_pin[0] == ($past(compare_secondary_rd[0]) != 16'h0000))
    else $error("pin wrong at rollover");
  a_duty_clear: assert property (pwm0 ##0 s_hit |=> !compare_output_pin[0])
    else $error("pin not cleared at duty match");
  a_match_high: assert property ((mode0 == 3'h2) ##0 s_hit |=>
    compare_output_pin[0] ##[0:1] compare_irq_flag[0])
    else $error("single compare high failed");
  a_wrap_flag: assert property (!$past(tb_wr.control_we) && $past(timer_count_a) != 16'h0000
    && timer_count_a == 16'h0000 |-> timebase_a_irq_flag)
    else $error("timer flag missing at rollover");
endmodule : ocp_compare_props

bind ocp_compare ocp_compare_props #(.NUM_CH(NUM_CH)) ocp_compare_props_i (.mclk(mclk),
  .rst(rst), .tb_wr(tb_wr), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
  .fault_input_a_n(fault_input_a_n), .compare_output_pin(compare_output_pin),
  .compare_output_pin_oe(compare_output_pin_oe), .compare_irq_flag(compare_irq_flag),
  .fault_flag(fault_flag), .compare_control_rd(compare_control_rd),
  .compare_main_rd(compare_main_rd), .compare_secondary_rd(compare_secondary_rd),
  .timer_count_a(timer_count_a), .timebase_a_irq_flag(timebase_a_irq_flag));

// [verif/ocp_pin_load.sv]
// Model of the pin load and the external fault source
`timescale 1ns/1ps
module ocp_pin_load (
  input wire logic pin,
  input wire logic pin_oe,
  input wire logic fault_req,
  output logic pad,
  output logic fault_n
);
  // Released pin is pulled high by the load
  assign pad = pin_oe ? pin : 1'b1;
  // Fault source pulls its line low on request
  assign fault_n = !fault_req;
endmodule : ocp_pin_load

// [verif/test_output_compare_pwm.sv]
// Self-checking bench for the output compare block
`timescale 1ns/1ps
module test_output_compare_pwm;
  import ocp_pkg::*;
  logic mclk, rst, fault_req, fault_n, pad0, irq_a, irq_b, sleep, tclr_a;
  logic [7:0] irq_clr, pin, oe, irq, flt;
  logic [7:0][15:0] ctl_rd, main_rd, sec_rd;
  logic [15:0] cnt_a, cnt_b;
  ocp_wr_t ch_wr;
  ocp_tbwr_t tb_wr;
  int err_total, tests_run, cyc, hi, t0;
  logic [15:0] mn [5] = '{16'h000a, 16'h000a, 16'h000a, 16'h000a, 16'h001e};
  logic [15:0] md [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0003, 16'h0001};
  logic [15:0] ex [5] = '{16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0001};

  ocp_compare ocp_compare_i (.mclk(mclk), .rst(rst), .ch_wr(ch_wr), .tb_wr(tb_wr),
    .cpu_idle(1'b0), .cpu_sleep(sleep), .fault_input_a_n(fault_n), .fault_input_b_n(1'b1),
    .compare_irq_clr(irq_clr), .timebase_a_irq_clr(tclr_a), .timebase_b_irq_clr(1'b0),
    .compare_output_pin(pin), .compare_output_pin_oe(oe), .compare_irq_flag(irq),
    .fault_flag(flt), .compare_control_rd(ctl_rd), .compare_main_rd(main_rd),
    .compare_secondary_rd(sec_rd), .timer_count_a(cnt_a), .timer_count_b(cnt_b),
    .timebase_a_irq_flag(irq_a), .timebase_b_irq_flag(irq_b));
  ocp_pin_load ocp_pin_load_i (.pin(pin[0]), .pin_oe(oe[0]), .fault_req(fault_req),
    .pad(pad0), .fault_n(fault_n));

  // ******************
  // Clock, timeout and tasks
  // ******************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_ch(input logic [2:0] c, input logic [2:0] we, input logic [15:0] d);
    ch_wr <= '{ch: c, ctrl_we: we[2], main_we: we[1], sec_we: we[0], data: d};
    @(posedge mclk);
    ch_wr <= '0;
    @(posedge mclk);
  endtask : wr_ch
  task automatic wr_tb(input logic s, input logic ctl, input logic [15:0] d);
    tb_wr <= '{tsel: s, period_we: !ctl, control_we: ctl, data: d};
    @(posedge mclk);
    tb_wr <= '0;
    @(posedge mclk);
  endtask : wr_tb
  task automatic wt(input logic b, input logic [15:0] v);
    for (int k = 0; k < 3000 && (b ? cnt_b : cnt_a) !== v; k++) @(posedge mclk);
  endtask : wt
  task automatic wt_chk(input logic b, input logic [15:0] v, input int c, input logic [15:0] e);
    wt(b, v);
    repeat (2) @(posedge mclk);
    chk(16'(pin[c]), e);
  endtask : wt_chk
  task automatic duty_chk(input logic [15:0] e);
    wt(1'b0, 16'h0000);
    wt(1'b0, 16'h0003);
    hi = 0;
    repeat (10) begin
      @(posedge mclk);
      hi += int'(pin[0]);
    end
    chk(16'(hi), e);
  endtask : duty_chk
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // ******************
  // Test sequence
  // ******************
  initial begin
    rst = 1'b1;
    ch_wr = '0;
    tb_wr = '0;
    irq_clr = '0;
    fault_req = 1'b0;
    sleep = 1'b0;
    tclr_a = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(ctl_rd[0], 16'h0000);
    chk(16'(oe), 16'h0000);
    wr_ch(3'h7, 3'b100, 16'h2003);
    chk(ctl_rd[7], 16'h2003);
    $display("test reset done");
    wr_tb(1'b0, 1'b0, 16'h0013);
    wr_tb(1'b0, 1'b1, 16'h8000);
    for (int i = 0; i < 5; i++) begin
      wt(1'b0, 16'h0001);
      wr_ch(3'h0, 3'b010, mn[i]);
      wr_ch(3'h0, 3'b100, md[i]);
      wt_chk(1'b0, 16'h0013, 0, ex[i]);
      chk(16'(irq[0]), 16'(i < 4));
      // Park the compare value out of range so the mode fires once per test
      wr_ch(3'h0, 3'b010, 16'h001e);
      irq_clr <= 8'h01;
      @(posedge mclk);
      irq_clr <= 8'h00;
    end
    $display("test single compare done");
    wr_ch(3'h1, 3'b010, 16'h000a);
    wr_ch(3'h1, 3'b001, 16'h0014);
    chk(sec_rd[1], 16'h0014);
    wr_tb(1'b1, 1'b0, 16'h001e);
    wr_ch(3'h1, 3'b100, 16'h000c);
    wr_tb(1'b1, 1'b1, 16'h8000);
    wt_chk(1'b1, 16'h000f, 1, 16'h0001);
    wt_chk(1'b1, 16'h0019, 1, 16'h0000);
    chk(16'(irq[1]), 16'h0001);
    wt_chk(1'b1, 16'h000f, 1, 16'h0000);
    wr_ch(3'h1, 3'b100, 16'h000c);
    wt_chk(1'b1, 16'h000f, 1, 16'h0001);
    wt_chk(1'b1, 16'h0019, 1, 16'h0000);
    wr_ch(3'h1, 3'b100, 16'h000d);
    wt_chk(1'b1, 16'h000f, 1, 16'h0001);
    wt_chk(1'b1, 16'h0019, 1, 16'h0000);
    wt_chk(1'b1, 16'h000f, 1, 16'h0001);
    $display("test dual compare done");
    wt(1'b0, 16'h0013);
    wr_tb(1'b0, 1'b1, 16'h0000);
    wr_tb(1'b0, 1'b0, 16'h0009);
    wr_ch(3'h0, 3'b001, 16'h0004);
    wr_ch(3'h0, 3'b100, 16'h0006);
    wr_tb(1'b0, 1'b1, 16'h8000);
    duty_chk(16'h0004);
    chk(main_rd[0], 16'h0004);
    wr_ch(3'h0, 3'b010, 16'h0007);
    chk(main_rd[0], 16'h0004);
    wr_ch(3'h0, 3'b001, 16'h0000);
    duty_chk(16'h0000);
    wr_tb(1'b0, 1'b1, 16'h8010);
    // Clear the timer flag well away from a rollover
    tclr_a <= 1'b1;
    @(posedge mclk);
    tclr_a <= 1'b0;
    @(posedge mclk);
    chk(16'(irq_a), 16'h0000);
    wt(1'b0, 16'h0000);
    wt(1'b0, 16'h0001);
    t0 = cyc;
    wt(1'b0, 16'h0000);
    wt(1'b0, 16'h0001);
    chk(16'(cyc - t0), 16'h0050);
    chk(16'(irq_a), 16'h0001);
    // Sleep freezes the timebase and holds the pin level
    sleep <= 1'b1;
    @(posedge mclk);
    t0 = cnt_a;
    hi = int'(pin[0]);
    repeat (20) @(posedge mclk);
    chk(cnt_a, 16'(t0));
    chk(16'(pin[0]), 16'(hi));
    sleep <= 1'b0;
    $display("test pwm done");
    wr_ch(3'h0, 3'b001, 16'h0004);
    wr_ch(3'h0, 3'b100, 16'h0007);
    repeat (20) @(posedge mclk);
    fault_req <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(16'(oe[0]), 16'h0000);
    chk(16'(pad0), 16'h0001);
    chk(16'(ctl_rd[0][4]), 16'h0001);
    fault_req <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(16'(flt[0]), 16'h0001);
    wr_ch(3'h0, 3'b100, 16'h0007);
    chk(16'(flt[0]), 16'h0000);
    chk(16'(oe[0]), 16'h0001);
    $display("test fault done");
    print_verdict();
  end
endmodule : test_output_compare_pwm
